/* File: cfgld_pkg.sv */
// Purpose: constants and types of the configuration loader
// Assumes: register word addresses are four times the byte index
// Notes:   one word per configuration byte, low eight bits used
package cfgld_pkg;

  // register indices and field positions
  localparam logic [31:0] MODE_IDX      = 32'h0030_0004;
  localparam logic [31:0] ROUTE_IDX     = 32'h0030_0005;
  localparam logic [31:0] DBG_IDX       = 32'h0030_0006;
  localparam logic [31:0] CP_IDX        = 32'h0030_0008;
  localparam int          ROUTE_SEL_BIT = 0;
  localparam int          RSV_BIT       = 1;
  localparam int          STV_BIT       = 0;
  localparam int          LV_PROG_BIT   = 2;
  localparam int          DEBUG_BIT     = 7;

  // values while unprogrammed
  localparam logic [1:0]  PM_UNPROG     = 2'h3;
  localparam logic [7:0]  CP_UNPROG     = 8'hff;
  localparam logic        BIT_UNPROG    = 1'h1;

  // bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    PM_EXT_SINGLE = 2'b00,
    PM_EXT_BOOT   = 2'b01,
    PM_EXT_MEM    = 2'b10,
    PM_SINGLE     = 2'b11
  } cfgld_mode_type;

  typedef enum logic [2:0] {
    REG_NONE  = 3'b000,
    REG_MODE  = 3'b001,
    REG_ROUTE = 3'b010,
    REG_DBG   = 3'b011,
    REG_CP    = 3'b100
  } cfgld_reg_type;

  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_RUN  = 1'b1
  } cfgld_load_type;

  typedef struct packed {
    logic [1:0] proc_memory_mode_sel;
    logic       capture2_pin_route_sel;
    logic       reserved_bit;
    logic       debugger_disable;
    logic       low_voltage_prog_enable;
    logic       stack_fault_reset_enable;
    logic [7:0] block_unprotect;
  } cfgld_cfg_type;

  localparam cfgld_cfg_type CFG_UNPROG = '{
    proc_memory_mode_sel     : PM_UNPROG,
    capture2_pin_route_sel   : BIT_UNPROG,
    reserved_bit             : BIT_UNPROG,
    debugger_disable         : BIT_UNPROG,
    low_voltage_prog_enable  : BIT_UNPROG,
    stack_fault_reset_enable : BIT_UNPROG,
    block_unprotect          : CP_UNPROG
  };

  // byte address of a register index
  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'b00};
  endfunction

endpackage

/* File: cfgld_sync.sv */
// Purpose: two-stage synchroniser for one level
// Assumes: input is asynchronous to i_clk
// Notes:   first stage read only by the second
`timescale 1ns/100ps
module cfgld_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // level
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* File: cfgld_top.sv */
// Purpose: configuration bytes, pin routing and feature enables
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   active copy taken after reset release and on reload
//
// Overview of operation
// - route byte bits seven to two always read zero
// - route byte bit one reads zero unless implemented
// - single-chip mode: unit two on port C pin one or port E pin seven
// - external modes: unit two on port C pin one or port B pin three
// - debug bit one frees port B pins six, seven; zero dedicates them
// - low-voltage programming entry accepted only when its bit is one
// - stack-fault bit one turns stack full or underflow into reset
// - programmable bits read one unprogrammed; unimplemented bits zero
// - mode bits 11 single, 10 external, 01 boot, 00 extended
// - each protect bit zero protects its program memory block
`timescale 1ns/100ps
module cfgld_top #(
  parameter bit RSV_IMPL = 1'b0
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // axi4-lite write
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // axi4-lite read
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // device events
  input  wire logic        i_cfg_reload,
  input  wire logic        i_stack_full,
  input  wire logic        i_stack_underflow,
  input  wire logic        i_lv_prog_entry,
  // configuration effects
  output logic [1:0]       o_proc_memory_mode_sel,
  output logic             o_port_c_pin_one,
  output logic             o_port_e_pin_seven,
  output logic             o_port_b_pin_three,
  output logic             o_debug_pins_dedicated,
  output logic             o_lv_prog_accept,
  output logic             o_stack_fault_reset,
  output logic [7:0]       o_block_protect
);

  function automatic cfgld_pkg::cfgld_reg_type decode(
    input logic [31:0] addr);
    if (addr == cfgld_pkg::byte_addr(cfgld_pkg::MODE_IDX)) begin
      decode = cfgld_pkg::REG_MODE;
    end else if (addr == cfgld_pkg::byte_addr(cfgld_pkg::ROUTE_IDX)) begin
      decode = cfgld_pkg::REG_ROUTE;
    end else if (addr == cfgld_pkg::byte_addr(cfgld_pkg::DBG_IDX)) begin
      decode = cfgld_pkg::REG_DBG;
    end else if (addr == cfgld_pkg::byte_addr(cfgld_pkg::CP_IDX)) begin
      decode = cfgld_pkg::REG_CP;
    end else begin
      decode = cfgld_pkg::REG_NONE;
    end
  endfunction

  cfgld_pkg::cfgld_cfg_type  cfg_q, cfg_d, act_q, act_d;
  cfgld_pkg::cfgld_load_type ld_q, ld_d;
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic        wlane_q, wlane_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  pm_q, pm_d;
  logic        pc1_q, pc1_d, pe7_q, pe7_d, pb3_q, pb3_d;
  logic        dbg_q, dbg_d, lva_q, lva_d, sfr_q, sfr_d;
  logic [7:0]  prot_q, prot_d;
  logic        lv_entry_sync;

  cfgld_sync u_lv_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_lv_prog_entry),
    .o_sync    (lv_entry_sync)
  );

  // bus slave and configuration store
  always_comb begin
    cfgld_pkg::cfgld_reg_type wsel;
    cfgld_pkg::cfgld_reg_type rsel;
    wsel      = decode(awaddr_q);
    rsel      = decode(i_araddr);
    cfg_d     = cfg_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (i_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d  = i_awaddr;
    end
    if (i_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d  = i_wdata;
      wlane_d  = i_wstrb[0];
    end
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == cfgld_pkg::REG_NONE) ?
                  cfgld_pkg::RESP_SLVERR : cfgld_pkg::RESP_OKAY;
      if (wlane_q) begin
        case (wsel)
          cfgld_pkg::REG_MODE: begin
            cfg_d.proc_memory_mode_sel = wdata_q[1:0];
          end
          cfgld_pkg::REG_ROUTE: begin
            cfg_d.capture2_pin_route_sel = wdata_q[cfgld_pkg::ROUTE_SEL_BIT];
            if (RSV_IMPL) begin
              cfg_d.reserved_bit = wdata_q[cfgld_pkg::RSV_BIT];
            end
          end
          cfgld_pkg::REG_DBG: begin
            cfg_d.debugger_disable = wdata_q[cfgld_pkg::DEBUG_BIT];
            cfg_d.low_voltage_prog_enable = wdata_q[cfgld_pkg::LV_PROG_BIT];
            cfg_d.stack_fault_reset_enable = wdata_q[cfgld_pkg::STV_BIT];
          end
          cfgld_pkg::REG_CP: begin
            cfg_d.block_unprotect = wdata_q[7:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0;
      rresp_d  = cfgld_pkg::RESP_OKAY;
      case (rsel)
        cfgld_pkg::REG_MODE: begin
          rdata_d[1:0] = cfg_q.proc_memory_mode_sel;
        end
        cfgld_pkg::REG_ROUTE: begin
          rdata_d[cfgld_pkg::ROUTE_SEL_BIT] = cfg_q.capture2_pin_route_sel;
          rdata_d[cfgld_pkg::RSV_BIT] = RSV_IMPL & cfg_q.reserved_bit;
        end
        cfgld_pkg::REG_DBG: begin
          rdata_d[cfgld_pkg::DEBUG_BIT] = cfg_q.debugger_disable;
          rdata_d[cfgld_pkg::LV_PROG_BIT] = cfg_q.low_voltage_prog_enable;
          rdata_d[cfgld_pkg::STV_BIT] = cfg_q.stack_fault_reset_enable;
        end
        cfgld_pkg::REG_CP: begin
          rdata_d[7:0] = cfg_q.block_unprotect;
        end
        default: begin
          rresp_d = cfgld_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // active copy and its effects
  always_comb begin
    ld_d  = cfgld_pkg::LD_RUN;
    act_d = act_q;
    if (ld_q == cfgld_pkg::LD_IDLE || i_cfg_reload) begin
      act_d = cfg_q;
    end
    pm_d  = act_q.proc_memory_mode_sel;
    pc1_d = act_q.capture2_pin_route_sel;
    pe7_d = 1'b0;
    pb3_d = 1'b0;
    if (!act_q.capture2_pin_route_sel) begin
      if (act_q.proc_memory_mode_sel == cfgld_pkg::PM_SINGLE) begin
        pe7_d = 1'b1;
      end else begin
        pb3_d = 1'b1;
      end
    end
    dbg_d  = !act_q.debugger_disable;
    lva_d  = act_q.low_voltage_prog_enable && lv_entry_sync;
    sfr_d  = act_q.stack_fault_reset_enable &&
             (i_stack_full || i_stack_underflow);
    prot_d = ~act_q.block_unprotect;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q     <= cfgld_pkg::CFG_UNPROG;
      act_q     <= cfgld_pkg::CFG_UNPROG;
      ld_q      <= cfgld_pkg::LD_IDLE;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
      pm_q      <= cfgld_pkg::PM_UNPROG;
      pc1_q     <= 1'b0;
      pe7_q     <= 1'b0;
      pb3_q     <= 1'b0;
      dbg_q     <= 1'b0;
      lva_q     <= 1'b0;
      sfr_q     <= 1'b0;
      prot_q    <= 8'h0;
    end else begin
      cfg_q     <= cfg_d;
      act_q     <= act_d;
      ld_q      <= ld_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      pm_q      <= pm_d;
      pc1_q     <= pc1_d;
      pe7_q     <= pe7_d;
      pb3_q     <= pb3_d;
      dbg_q     <= dbg_d;
      lva_q     <= lva_d;
      sfr_q     <= sfr_d;
      prot_q    <= prot_d;
    end
  end

  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;
  assign o_proc_memory_mode_sel = pm_q;
  assign o_port_c_pin_one       = pc1_q;
  assign o_port_e_pin_seven     = pe7_q;
  assign o_port_b_pin_three     = pb3_q;
  assign o_debug_pins_dedicated = dbg_q;
  assign o_lv_prog_accept       = lva_q;
  assign o_stack_fault_reset    = sfr_q;
  assign o_block_protect        = prot_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_route_upper_zero: assert property (
    (i_arvalid && arready_q && decode(i_araddr) == cfgld_pkg::REG_ROUTE)
    |=> rdata_q[31:2] == 30'h0) else $error("route upper bits not zero");
  a_route_rsv_zero: assert property (
    (!RSV_IMPL && i_arvalid && arready_q &&
     decode(i_araddr) == cfgld_pkg::REG_ROUTE)
    |=> !rdata_q[1]) else $error("reserved bit not zero");
  a_route_single_chip: assert property (
    (ld_q == cfgld_pkg::LD_RUN &&
     act_q.proc_memory_mode_sel == cfgld_pkg::PM_SINGLE)
    |=> (pc1_q == $past(act_q.capture2_pin_route_sel)) &&
        (pe7_q == !$past(act_q.capture2_pin_route_sel)) && !pb3_q)
    else $error("single-chip routing wrong");
  a_route_ext_mode: assert property (
    (act_q.proc_memory_mode_sel != cfgld_pkg::PM_SINGLE)
    |=> (pb3_q == !$past(act_q.capture2_pin_route_sel)) && !pe7_q)
    else $error("external-mode routing wrong");
  a_debug_pins: assert property (
    ##1 dbg_q == !$past(act_q.debugger_disable))
    else $error("debug pin ownership wrong");
  a_lv_prog_gate: assert property (
    lva_q |-> $past(act_q.low_voltage_prog_enable) && $past(lv_entry_sync))
    else $error("low-voltage entry accepted while disabled");
  a_stack_reset: assert property (
    (i_stack_full || i_stack_underflow)
    |=> sfr_q == $past(act_q.stack_fault_reset_enable))
    else $error("stack fault reset wrong");
  a_unprog_ones: assert property (
    ld_q == cfgld_pkg::LD_IDLE |-> cfg_q == cfgld_pkg::CFG_UNPROG)
    else $error("store not unprogrammed after reset");
  a_mode_out: assert property (
    ##1 pm_q == $past(act_q.proc_memory_mode_sel))
    else $error("mode output wrong");
  a_block_protect: assert property (
    ##2 prot_q == ~$past(act_q.block_unprotect, 1))
    else $error("block protect wrong");
  a_latch_stable: assert property (
    (ld_q == cfgld_pkg::LD_RUN && !i_cfg_reload) |=> $stable(act_q))
    else $error("active configuration changed while running");

  c_write: cover property (aw_full_q && w_full_q ##1 bvalid_q);
  c_read: cover property (i_arvalid && arready_q ##1 rvalid_q);
  c_stack: cover property (sfr_q);
  c_lv_prog: cover property (lva_q);
endmodule

/* File: cfgld_top_bench.sv */
// Purpose: self-checking bench for the configuration loader
// Assumes: axi4-lite master driven on rising edges
// Notes:   effects sampled 1 ns after the edge
`timescale 1ns/100ps
module cfgld_top_bench;
  localparam logic [31:0] MODE_A = cfgld_pkg::MODE_IDX << 2;
  localparam logic [31:0] ROUTE_A = cfgld_pkg::ROUTE_IDX << 2;
  localparam logic [31:0] DBG_A = cfgld_pkg::DBG_IDX << 2;
  localparam logic [31:0] CP_A = cfgld_pkg::CP_IDX << 2;
  localparam logic [31:0] BAD_A = 32'h00c0_001c;
  logic i_clk = 1'b0, i_reset_n = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0;
  logic i_rready = 1'b0, i_cfg_reload = 1'b0, i_stack_full = 1'b0;
  logic i_stack_underflow = 1'b0, i_lv_prog_entry = 1'b0;
  logic [31:0] i_awaddr = '0, i_wdata = '0, i_araddr = '0;
  logic [3:0] i_wstrb = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, o_proc_memory_mode_sel;
  logic [31:0] o_rdata;
  logic o_port_c_pin_one, o_port_e_pin_seven, o_port_b_pin_three;
  logic o_debug_pins_dedicated, o_lv_prog_accept, o_stack_fault_reset;
  logic [7:0] o_block_protect, e_prot;
  logic [1:0] e_mode, rsp;
  logic e_sel, e_dbg;
  logic [31:0] rd;
  int fails = 0, tests_run = 0;
  cfgld_top DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_cfg_reload(i_cfg_reload),
    .i_stack_full(i_stack_full), .i_stack_underflow(i_stack_underflow),
    .i_lv_prog_entry(i_lv_prog_entry),
    .o_proc_memory_mode_sel(o_proc_memory_mode_sel),
    .o_port_c_pin_one(o_port_c_pin_one),
    .o_port_e_pin_seven(o_port_e_pin_seven),
    .o_port_b_pin_three(o_port_b_pin_three),
    .o_debug_pins_dedicated(o_debug_pins_dedicated),
    .o_lv_prog_accept(o_lv_prog_accept),
    .o_stack_fault_reset(o_stack_fault_reset),
    .o_block_protect(o_block_protect));
  always #5 i_clk = ~i_clk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_awvalid && o_awready === 1'b1) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready === 1'b1) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1 && n < 50);
    rsp = o_bresp;
    i_bready <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic axi_read(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_arvalid && o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1 && n < 50);
    rd = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic reload();
    @(posedge i_clk);
    i_cfg_reload <= 1'b1;
    @(posedge i_clk);
    i_cfg_reload <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic check_fx();
    logic [31:0] e;
    e = {18'h0, e_mode, e_sel, ~e_sel & (e_mode == 2'h3),
         ~e_sel & (e_mode != 2'h3), ~e_dbg, ~e_prot};
    check({18'h0, o_proc_memory_mode_sel, o_port_c_pin_one,
           o_port_e_pin_seven, o_port_b_pin_three,
           o_debug_pins_dedicated, o_block_protect}, e);
  endtask
  // stack full, underflow, then low-voltage entry, each held then dropped
  task automatic event_chk(input logic en);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_stack_full <= (k == 0);
      i_stack_underflow <= (k == 1);
      i_lv_prog_entry <= (k == 2);
      repeat (4) @(posedge i_clk);
      #1;
      check({31'h0, (k == 2) ? o_lv_prog_accept : o_stack_fault_reset},
            {31'h0, en});
      @(posedge i_clk);
      {i_stack_full, i_stack_underflow, i_lv_prog_entry} <= 3'h0;
      repeat (4) @(posedge i_clk);
      #1;
      check({30'h0, o_lv_prog_accept, o_stack_fault_reset}, 32'h0);
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    stop_test();
  end
  initial begin
    e_mode = 2'h3;
    e_sel = 1'b1;
    e_dbg = 1'b1;
    e_prot = 8'hff;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    check_fx();
    axi_read(MODE_A);
    check(rd, 32'h3);
    axi_read(ROUTE_A);
    check(rd, 32'h1);
    axi_read(DBG_A);
    check(rd, 32'h85);
    axi_read(CP_A);
    check(rd, 32'hff);
    $display("test reset_values done");
    axi_write(ROUTE_A, 32'hffff_ffff, 4'hf);
    check({30'h0, rsp}, {30'h0, cfgld_pkg::RESP_OKAY});
    axi_read(ROUTE_A);
    check(rd, 32'h1);
    axi_write(DBG_A, 32'hffff_ffff, 4'hf);
    axi_read(DBG_A);
    check(rd, 32'h85);
    axi_write(DBG_A, 32'h0, 4'hf);
    axi_read(DBG_A);
    check(rd, 32'h0);
    axi_write(BAD_A, 32'h1, 4'hf);
    check({30'h0, rsp}, {30'h0, cfgld_pkg::RESP_SLVERR});
    axi_read(BAD_A);
    check({rd[29:0], rsp}, {30'h0, cfgld_pkg::RESP_SLVERR});
    $display("test read_only_bits done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        axi_write(MODE_A, m, 4'h1);
        axi_write(ROUTE_A, s, 4'h1);
        #1;
        check_fx();
        reload();
        e_mode = m[1:0];
        e_sel = s[0];
        e_dbg = 1'b0;
        check_fx();
      end
    end
    $display("test pin_routing done");
    event_chk(1'b0);
    axi_write(DBG_A, 32'h85, 4'h1);
    reload();
    e_dbg = 1'b1;
    check_fx();
    event_chk(1'b1);
    $display("test debug_stack done");
    axi_write(CP_A, 32'ha5, 4'h1);
    axi_write(CP_A, 32'h0, 4'h0);
    axi_read(CP_A);
    check(rd, 32'ha5);
    #1;
    check_fx();
    reload();
    e_prot = 8'ha5;
    check_fx();
    $display("test code_protect done");
    stop_test();
  end
endmodule
